// *** shared/failsafe_pkg.sv ***
// Constants, state encoding and timing for the failsafe watchdog supervisor
package failsafe_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  // Watchdog interval, ns (10 ms)
  localparam int unsigned WD_INTERVAL_NS = 10_000_000;
  // Longest time, rounded down
  localparam int unsigned WD_INTERVAL_CYC = WD_INTERVAL_NS / CLK_PERIOD_NS;
  // Least accepted kick low time, ns
  localparam int unsigned KICK_MIN_NS = 150;
  // Least time, rounded up
  localparam int unsigned KICK_MIN_CYC =
    (KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int unsigned TMR_W = 20;
  localparam int unsigned KICK_CNT_W = 4;
  localparam int unsigned SYNC_W = 5;
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h10;
  localparam logic OUT_RST = 1'b0;

  // ****************************************
  // Synchroniser bit positions
  // ****************************************
  localparam int unsigned SB_SUPPLY = 0;
  localparam int unsigned SB_UPPER = 1;
  localparam int unsigned SB_WARN = 2;
  localparam int unsigned SB_LOW = 3;
  localparam int unsigned SB_KICK = 4;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [4:0] {
    ST_OFF  = 5'h01,
    ST_ARM  = 5'h02,
    ST_POR  = 5'h04,
    ST_RUN  = 5'h08,
    ST_TRIP = 5'h10
  } seq_state_e;

endpackage

// *** shared/cond_if.sv ***
// Conditioned comparator levels and kick strobe between the two modules
`timescale 1ns/1ps
interface cond_if;
  logic supply_ok;
  logic above_upper;
  logic above_warn;
  logic above_low;
  logic kick_strobe;

  modport src (
    output supply_ok,
    output above_upper,
    output above_warn,
    output above_low,
    output kick_strobe
  );

  modport dst (
    input supply_ok,
    input above_upper,
    input above_warn,
    input above_low,
    input kick_strobe
  );
endinterface

// *** rtl/input_conditioner.sv ***
// Pin synchronisers and kick pulse qualifier
`timescale 1ns/1ps
module input_conditioner
  import failsafe_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic supply_on,
  input wire logic vin_above_upper,
  input wire logic vin_above_warn,
  input wire logic vin_above_low,
  input wire logic watchdog_kick_n,
  cond_if.src cond
);

  // ****************************************
  // Two-stage synchronisers
  // ****************************************
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [KICK_CNT_W-1:0] kick_cnt_ff;
  logic [KICK_CNT_W-1:0] nxt_kick_cnt;
  logic kick_strobe_ff;
  logic nxt_kick_strobe;

  assign pins = {watchdog_kick_n, vin_above_low, vin_above_warn,
                 vin_above_upper, supply_on};

  // R18: two flops per pin
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_ff[gi] <= SYNC_RST[gi];
          sync2_ff[gi] <= SYNC_RST[gi];
        end else begin
          sync1_ff[gi] <= pins[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // Kick qualifier
  // ****************************************
  // R10: low for the least pulse width gives one strobe
  always_comb begin
    nxt_kick_cnt = kick_cnt_ff;
    nxt_kick_strobe = 1'b0;
    if (sync2_ff[SB_KICK]) begin
      nxt_kick_cnt = '0;
    end else if (kick_cnt_ff != KICK_CNT_W'(KICK_MIN_CYC)) begin
      nxt_kick_cnt = kick_cnt_ff + 1'b1;
      nxt_kick_strobe = (kick_cnt_ff == KICK_CNT_W'(KICK_MIN_CYC - 1));
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      kick_cnt_ff <= '0;
      kick_strobe_ff <= 1'b0;
    end else begin
      kick_cnt_ff <= nxt_kick_cnt;
      kick_strobe_ff <= nxt_kick_strobe;
    end
  end

  assign cond.supply_ok = sync2_ff[SB_SUPPLY];
  assign cond.above_upper = sync2_ff[SB_UPPER];
  assign cond.above_warn = sync2_ff[SB_WARN];
  assign cond.above_low = sync2_ff[SB_LOW];
  assign cond.kick_strobe = kick_strobe_ff;

  // ****************************************
  // Checks
  // ****************************************
  AST_KICK_ONE_SHOT: assert property ( // R10
    @(posedge core_clk) disable iff (!reset_n)
    kick_strobe_ff |=> !kick_strobe_ff)
    else $error("kick strobe longer than one cycle");

  AST_KICK_NEEDS_LOW: assert property ( // R10
    @(posedge core_clk) disable iff (!reset_n)
    $rose(kick_strobe_ff) |-> $past(!sync2_ff[SB_KICK], 1)
      && $past(!sync2_ff[SB_KICK], 8))
    else $error("kick accepted without full low time");

endmodule

// *** rtl/failsafe_watchdog_supervisor.sv ***
// Sequencer of the failsafe watchdog and supply supervisor
//
// Notes on behaviour
// R1: Supply below on level: ignore voltage inputs, hold reset and save low.
// R2: Supply lost after running: stop timer and monitoring, reset and save low.
// R3: Supply on and input above upper: save high, reset high one interval on.
// R4: Input below warn level: save low until above upper level again.
// R5: Input below low level: reset low and timer stops.
// R6: Recovery above upper after low trip restarts full power-up delay.
// R7: Idle oscillator chain gives a ten millisecond interval.
// R8: Static kick input yields a warning square wave of two intervals.
// R9: Without watchdog use, system loops warning output back to kick input.
// R10: Kick low longer than 150 ns clears timer, warning goes high.
// R11: Each kick inside the interval zeroes the timer, warning stays high.
// R12: No kick within interval: warning low, then toggles each interval.
// R13: No kick in first warning low phase: reset low until kick or power-up.
// R14: Kicks ignored during the power-on reset delay.
// R15: Kick in normal operation clears timer, warning and reset go high.
// R16: Low trip overrides timer: reset and save low, warning disabled.
// R17: After low trip, kicks ignored until next power-up completes.
// R18: Comparator and kick inputs pass two flops before use.
// R19: Supply off holds the sequencer in power-down with outputs low.
`timescale 1ns/1ps
module failsafe_watchdog_supervisor
  import failsafe_pkg::*;
#(
  parameter int unsigned INTERVAL_CYC = WD_INTERVAL_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic supply_on,
  input wire logic vin_above_upper,
  input wire logic vin_above_warn,
  input wire logic vin_above_low,
  input wire logic watchdog_kick_n,
  output logic timeout_warning_n,
  output logic powerfail_warn_n,
  output logic sys_rst_out_n
);

  // ****************************************
  // Input conditioning
  // ****************************************
  cond_if cond ();

  // R18: all pins synchronised here
  input_conditioner u_cond (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .supply_on(supply_on),
    .vin_above_upper(vin_above_upper),
    .vin_above_warn(vin_above_warn),
    .vin_above_low(vin_above_low),
    .watchdog_kick_n(watchdog_kick_n),
    .cond(cond)
  );

  // ****************************************
  // Sequencer state
  // ****************************************
  seq_state_e state_ff;
  seq_state_e nxt_state;
  logic [TMR_W-1:0] tmr_ff;
  logic [TMR_W-1:0] nxt_tmr;
  logic to_ff;
  logic nxt_to;
  logic save_ff;
  logic nxt_save;
  logic rst_ff;
  logic nxt_rst;
  logic expire;
  logic kick;
  logic low_trip;

  // R7: one interval is INTERVAL_CYC clocks
  assign expire = (tmr_ff == TMR_W'(INTERVAL_CYC - 1));
  assign kick = cond.kick_strobe;
  assign low_trip = !cond.above_low;

  always_comb begin
    nxt_state = state_ff;
    nxt_tmr = tmr_ff;
    nxt_to = to_ff;
    nxt_save = save_ff;
    nxt_rst = rst_ff;
    if (!cond.supply_ok) begin
      // R1: comparators not looked at below the on level
      // R2: timer and monitoring stop on supply loss
      // R19: power-down state, every output low
      nxt_state = ST_OFF;
      nxt_tmr = '0;
      nxt_to = 1'b0;
      nxt_save = 1'b0;
      nxt_rst = 1'b0;
    end else begin
      unique case (state_ff)
        ST_OFF: begin
          nxt_state = ST_ARM;
          nxt_to = 1'b1;
        end
        ST_ARM: begin
          // R3: upper crossing starts the power-on delay
          if (cond.above_upper) begin
            nxt_state = ST_POR;
            nxt_tmr = '0;
            nxt_save = 1'b1;
          end
        end
        ST_POR: begin
          if (low_trip) begin
            // R16: low trip wins over timer
            nxt_state = ST_TRIP;
            nxt_tmr = '0;
            nxt_to = 1'b1;
            nxt_save = 1'b0;
            nxt_rst = 1'b0;
          end else begin
            // R4: save follows warn and upper hysteresis
            if (!cond.above_warn) begin
              nxt_save = 1'b0;
            end else if (cond.above_upper) begin
              nxt_save = 1'b1;
            end
            // R14: kick not looked at during the delay
            // R3: reset released after one interval
            if (expire) begin
              nxt_state = ST_RUN;
              nxt_tmr = '0;
              nxt_to = 1'b1;
              nxt_rst = 1'b1;
            end else begin
              nxt_tmr = tmr_ff + 1'b1;
            end
          end
        end
        ST_RUN: begin
          if (low_trip) begin
            // R5: reset low and timer halted
            // R16: save low, warning held inactive
            nxt_state = ST_TRIP;
            nxt_tmr = '0;
            nxt_to = 1'b1;
            nxt_save = 1'b0;
            nxt_rst = 1'b0;
          end else begin
            // R4: save follows warn and upper hysteresis
            if (!cond.above_warn) begin
              nxt_save = 1'b0;
            end else if (cond.above_upper) begin
              nxt_save = 1'b1;
            end
            if (kick) begin
              // R11: kick zeroes timer
              // R15: warning and reset back high
              nxt_tmr = '0;
              nxt_to = 1'b1;
              nxt_rst = 1'b1;
            end else if (expire) begin
              // R12: first expiry drives warning low, then toggles
              // R8: static kick gives period of two intervals
              nxt_tmr = '0;
              nxt_to = !to_ff;
              // R13: end of a low phase without kick asserts reset
              if (!to_ff) begin
                nxt_rst = 1'b0;
              end
            end else begin
              nxt_tmr = tmr_ff + 1'b1;
            end
          end
        end
        ST_TRIP: begin
          // R17: kicks ignored until a fresh power-up
          // R6: recovery restarts the complete delay
          if (cond.above_upper) begin
            nxt_state = ST_POR;
            nxt_tmr = '0;
            nxt_save = 1'b1;
          end
        end
        default: begin
          nxt_state = ST_OFF;
          nxt_tmr = '0;
          nxt_to = 1'b0;
          nxt_save = 1'b0;
          nxt_rst = 1'b0;
        end
      endcase
    end
  end

  // Outputs come straight from these flops; low while in reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_OFF;
      tmr_ff <= '0;
      to_ff <= OUT_RST;
      save_ff <= OUT_RST;
      rst_ff <= OUT_RST;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      to_ff <= nxt_to;
      save_ff <= nxt_save;
      rst_ff <= nxt_rst;
    end
  end

  assign timeout_warning_n = to_ff;
  assign powerfail_warn_n = save_ff;
  assign sys_rst_out_n = rst_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  AST_OFF_ALL_LOW: assert property ( // R19
    !cond.supply_ok |=> !to_ff && !save_ff && !rst_ff && state_ff == ST_OFF)
    else $error("outputs not low with supply off");

  AST_ARM_HOLDS_LOW: assert property ( // R3
    cond.supply_ok && state_ff == ST_ARM && !cond.above_upper
      |=> !rst_ff && !save_ff)
    else $error("reset or save released before upper crossing");

  AST_POR_START: assert property ( // R3
    cond.supply_ok && state_ff == ST_ARM && cond.above_upper
      |=> state_ff == ST_POR && save_ff && !rst_ff && tmr_ff == '0)
    else $error("power-on delay did not start");

  AST_POR_RELEASE: assert property ( // R3
    cond.supply_ok && state_ff == ST_POR && !low_trip && expire
      |=> rst_ff && to_ff && state_ff == ST_RUN)
    else $error("reset not released after power-on delay");

  AST_POR_NO_KICK: assert property ( // R14
    cond.supply_ok && state_ff == ST_POR && !low_trip && !expire && kick
      |=> !rst_ff && tmr_ff == $past(tmr_ff) + 1'b1)
    else $error("kick acted during power-on delay");

  AST_WARN_SAVE: assert property ( // R4
    cond.supply_ok && state_ff == ST_RUN && !low_trip && !cond.above_warn
      |=> !save_ff)
    else $error("save not driven low below warn level");

  AST_LOW_TRIP: assert property ( // R16
    cond.supply_ok && low_trip && (state_ff == ST_RUN || state_ff == ST_POR)
      |=> !rst_ff && !save_ff && to_ff && state_ff == ST_TRIP)
    else $error("low trip did not force reset and save");

  AST_TRIP_IGNORES_KICK: assert property ( // R17
    cond.supply_ok && state_ff == ST_TRIP && !cond.above_upper
      |=> state_ff == ST_TRIP && !rst_ff && tmr_ff == '0)
    else $error("trip state left without upper crossing");

  AST_KICK_CLEARS: assert property ( // R15
    cond.supply_ok && state_ff == ST_RUN && !low_trip && kick
      |=> to_ff && rst_ff && tmr_ff == '0)
    else $error("kick did not clear timer and outputs");

  AST_TOGGLE: assert property ( // R12
    cond.supply_ok && state_ff == ST_RUN && !low_trip && !kick && expire
      |=> to_ff != $past(to_ff) && tmr_ff == '0)
    else $error("warning did not toggle at expiry");

  AST_RST_AFTER_LOW: assert property ( // R13
    cond.supply_ok && state_ff == ST_RUN && !low_trip && !kick && expire
      && !to_ff |=> !rst_ff)
    else $error("reset not asserted after low warning phase");

  AST_RUN_COUNTS: assert property ( // R11
    cond.supply_ok && state_ff == ST_RUN && !low_trip && !kick && !expire
      |=> tmr_ff == $past(tmr_ff) + 1'b1 && to_ff == $past(to_ff))
    else $error("timer did not advance in run");

endmodule

// *** testbench/host_kick_model.sv ***
// Host processor model issuing watchdog clear pulses
`timescale 1ns/1ps
module host_kick_model (
  input wire logic core_clk,
  input wire logic auto_kick,
  input wire logic loop_back,
  input wire logic timeout_warning_n,
  output logic watchdog_kick_n
);
  integer seed = 32'h2ced8724;

  initial watchdog_kick_n = 1'b1;

  // ****************************************
  // Clear pulses
  // ****************************************
  // low longer than 150 ns
  task automatic kick_once();
    int low_cyc;
    int high_cyc;
    low_cyc = 9 + ($unsigned($random(seed)) % 4);
    high_cyc = 3 + ($unsigned($random(seed)) % 3);
    @(negedge core_clk);
    watchdog_kick_n = 1'b0;
    repeat (low_cyc) @(negedge core_clk);
    watchdog_kick_n = 1'b1;
    repeat (high_cyc) @(negedge core_clk);
  endtask

  // Period stays at 18 cycles or less, inside a 20 cycle interval
  // One process, so loop-back and kicks never drive the pin together
  always begin
    @(negedge core_clk);
    if (loop_back) begin
      // warning output fed back as kick
      watchdog_kick_n = timeout_warning_n;
    end else begin
      while (auto_kick) kick_once();
    end
  end
endmodule

// *** testbench/failsafe_watchdog_supervisor_test.sv ***
// Self-checking bench for the failsafe watchdog supervisor
`timescale 1ns/1ps
module failsafe_watchdog_supervisor_test
  import failsafe_pkg::*;
;
  localparam int unsigned IVL = 20;
  typedef struct {
    logic [2:0] val;
    int gap;
  } note_s;
  logic core_clk;
  logic reset_n;
  logic supply_on;
  logic vin_above_upper;
  logic vin_above_warn;
  logic vin_above_low;
  logic auto_kick;
  logic loop_back;
  logic watchdog_kick_n;
  logic timeout_warning_n;
  logic powerfail_warn_n;
  logic sys_rst_out_n;
  logic [2:0] last_out;
  logic [2:0] outs;
  note_s notes[$];
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int gap_cnt = 0;

  assign outs = {timeout_warning_n, powerfail_warn_n, sys_rst_out_n};

  failsafe_watchdog_supervisor #(.INTERVAL_CYC(IVL))
    failsafe_watchdog_supervisor_inst (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .supply_on(supply_on),
    .vin_above_upper(vin_above_upper),
    .vin_above_warn(vin_above_warn),
    .vin_above_low(vin_above_low),
    .watchdog_kick_n(watchdog_kick_n),
    .timeout_warning_n(timeout_warning_n),
    .powerfail_warn_n(powerfail_warn_n),
    .sys_rst_out_n(sys_rst_out_n)
  );

  host_kick_model host_kick_model_inst (
    .core_clk(core_clk),
    .auto_kick(auto_kick),
    .loop_back(loop_back),
    .timeout_warning_n(timeout_warning_n),
    .watchdog_kick_n(watchdog_kick_n)
  );

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic compare_out(input logic [2:0] got, input int gap,
                             input note_s exp_n);
    total_checks++;
    if (got !== exp_n.val || (exp_n.gap != 0 && gap != exp_n.gap)) begin
      failures++;
      $display("[FAIL] %0t outputs %b after %0d, expected %b after %0d",
               $time, got, gap, exp_n.val, exp_n.gap);
    end
  endtask

  task automatic note_out(input logic [2:0] v, input int g);
    notes.push_back('{v, g});
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wait_done(input int limit);
    int n;
    n = 0;
    while (notes.size() != 0 && n < limit) begin
      @(negedge core_clk);
      n++;
    end
    if (notes.size() != 0) begin
      failures++;
      $display("[FAIL] %0t expected output change missing", $time);
      notes.delete();
    end
  endtask

  task automatic set_vin(input logic v);
    vin_above_upper = v;
    vin_above_warn = v;
    vin_above_low = v;
  endtask

  // Outputs are flop driven, so the falling edge sees settled values
  always @(negedge core_clk) begin
    if (reset_n === 1'b1) begin
      gap_cnt++;
      if (outs !== last_out) begin
        last_out = outs;
        if (notes.size() == 0) begin
          failures++;
          total_checks++;
          $display("[FAIL] %0t unexpected output change %b", $time, outs);
        end else begin
          compare_out(outs, gap_cnt, notes.pop_front());
        end
        gap_cnt = 0;
      end
    end
  end

  // Whole sequence needs under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("[FAIL] %0t run did not finish", $time);
      stop_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset_n = 1'b0;
    supply_on = 1'b0;
    auto_kick = 1'b0;
    loop_back = 1'b0;
    set_vin(1'b1);
    last_out = {3{OUT_RST}};
    idle(6);
    reset_n = 1'b1;
    idle(10);
    compare_out(outs, 0, '{{3{OUT_RST}}, 0});
    set_vin(1'b0);
    supply_on = 1'b1;
    note_out(3'b100, 0);
    wait_done(10);
    note_out(3'b110, 0);
    note_out(3'b111, IVL);
    set_vin(1'b1);
    idle(5);
    host_kick_model_inst.kick_once();
    wait_done(40);
    note_out(3'b011, IVL);
    note_out(3'b110, IVL);
    note_out(3'b010, IVL);
    note_out(3'b110, IVL);
    wait_done(100);
    note_out(3'b111, 0);
    host_kick_model_inst.kick_once();
    wait_done(20);
    auto_kick = 1'b1;
    idle(100);
    note_out(3'b011, 0);
    auto_kick = 1'b0;
    wait_done(60);
    note_out(3'b111, 0);
    host_kick_model_inst.kick_once();
    wait_done(20);
    auto_kick = 1'b1;
    note_out(3'b101, 0);
    vin_above_upper = 1'b0;
    vin_above_warn = 1'b0;
    wait_done(10);
    vin_above_warn = 1'b1;
    idle(30);
    note_out(3'b111, 0);
    vin_above_upper = 1'b1;
    wait_done(10);
    note_out(3'b100, 0);
    set_vin(1'b0);
    wait_done(10);
    idle(60);
    note_out(3'b110, 0);
    note_out(3'b111, IVL);
    set_vin(1'b1);
    wait_done(40);
    // Loop-back low phase: two sync flops, kick count up to the strobe flop, warning flop
    auto_kick = 1'b0;
    loop_back = 1'b1;
    note_out(3'b011, 0);
    note_out(3'b111, KICK_MIN_CYC + 3);
    note_out(3'b011, IVL);
    note_out(3'b111, KICK_MIN_CYC + 3);
    wait_done(100);
    idle(1);
    loop_back = 1'b0;
    auto_kick = 1'b1;
    idle(60);
    note_out(3'b000, 0);
    supply_on = 1'b0;
    wait_done(10);
    auto_kick = 1'b0;
    idle(40);
    stop_test();
  end
endmodule
